/* hdl/apc_defs.svh */
// Constants shared by the converter control ends
`ifndef APC_DEFS_SVH
`define APC_DEFS_SVH
`define APC_BIT_PD_HI   7
`define APC_BIT_PD_LO   6
`define APC_BIT_ACQ     5
`define APC_BIT_SGL     4
`define APC_BIT_UNI     3
`define APC_PD_SHUT     2'h0
`define APC_PD_STBY     2'h1
`define APC_PD_INT      2'h2
`define APC_PD_EXT      2'h3
`define APC_ACQ_TICKS   4'h3
`define APC_CONV_TICKS  4'hd
`define APC_FRAME_TICKS 18
`define APC_PIPE_TICKS  16
`define APC_BIP_FLIP    12'h800
`define APC_CLK_MHZ     20
`define APC_T_RESET_US  10
`define APC_T_REF_US    500
`define APC_T_WAKE_US   50
`define APC_RESET_CYC   (`APC_T_RESET_US * `APC_CLK_MHZ)
`define APC_REF_CYC     (`APC_T_REF_US * `APC_CLK_MHZ)
`define APC_WAKE_CYC    (`APC_T_WAKE_US * `APC_CLK_MHZ)
`endif

/* hdl/apc_pkg.sv */
// Types shared by the converter control ends
package apc_pkg;
    typedef enum logic [3:0] {
        APC_IDLE    = 4'h1,
        APC_ACQ_INT = 4'h2,
        APC_ACQ_EXT = 4'h4,
        APC_CONV    = 4'h8
    } apc_cnv_t;
    typedef enum logic [2:0] {
        APC_ACTIVE = 3'h1,
        APC_STBY   = 3'h2,
        APC_SHUT   = 3'h4
    } apc_pwr_t;
    typedef enum logic [6:0] {
        APC_H_RST  = 7'h01,
        APC_H_IDLE = 7'h02,
        APC_H_WR   = 7'h04,
        APC_H_WAKE = 7'h08,
        APC_H_RD   = 7'h10,
        APC_H_WAIT = 7'h20
    } apc_host_t;
endpackage

/* hdl/apc_bus_if.sv */
// Parallel bus between the host and the converter
`timescale 1ns/100ps
interface apc_bus_if;
    logic        cs_n;
    logic        wr_n;
    logic        rd_n;
    logic        conv_clk;
    logic        int_n;
    logic [15:0] host_d;
    logic        host_oe;
    logic [15:0] dev_d;
    logic        dev_oe;
    logic [15:0] data;
    // Shared data wire level from the enables
    assign data = dev_oe ? dev_d : (host_oe ? host_d : 16'h0000);
    modport dev  (input cs_n, wr_n, rd_n, conv_clk, data, output int_n, dev_d, dev_oe);
    modport host (output cs_n, wr_n, rd_n, conv_clk, host_d, host_oe, input data, int_n);
endinterface

/* hdl/apc_dev.sv */
// Converter end: control byte, power modes, conversion frame
`timescale 1ns/100ps
`include "apc_defs.svh"
module apc_dev
    import apc_pkg::*;
#(
    parameter int INT_DIV = 6
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    apc_bus_if.dev           bus,
    input  wire logic [11:0] analog_in,
    output logic      [2:0]  power_out,
    output logic             clk_ext_out,
    output logic      [2:0]  chan_out,
    output logic             sgl_out,
    output logic             hold_out
);
    logic [7:0]  byte_reg;
    logic [7:0]  ctrl_reg;
    logic        wr_prev_reg;
    logic        rd_prev_reg;
    logic        cclk_prev_reg;
    logic        clk_ext_reg;
    logic        pd_pend_reg;
    logic        pd_stby_reg;
    apc_cnv_t    state_reg;
    apc_pwr_t    pwr_reg;
    logic [3:0]  tick_cnt_reg;
    logic [7:0]  div_cnt_reg;
    logic [11:0] sample_reg;
    logic [11:0] result_reg;
    logic        int_n_reg;
    logic        oe_reg;
    logic [15:0] dout_reg;
    logic        hold_reg;
    logic        wr_rise;
    logic        rd_fall;
    logic        int_tick;
    logic        tick;
    logic        acq_end;
    logic        conv_end;
    logic        start_conv;
    logic        pd_byte;

    // Output code from the held sample
    function automatic logic [11:0] code_of(input logic [11:0] a, input logic uni);
        code_of = uni ? a : (a ^ `APC_BIP_FLIP);
    endfunction

    // Strobe edges and conversion clock ticks
    assign wr_rise  = bus.wr_n & ~wr_prev_reg & ~bus.cs_n;
    assign rd_fall  = ~bus.rd_n & rd_prev_reg & ~bus.cs_n;
    assign int_tick = (div_cnt_reg == 8'(INT_DIV - 1));
    assign tick     = clk_ext_reg ? (bus.conv_clk & ~cclk_prev_reg) : int_tick;
    assign acq_end  = (state_reg == APC_ACQ_INT) & tick & (tick_cnt_reg == `APC_ACQ_TICKS - 4'h1);
    assign conv_end = ~wr_rise & (state_reg == APC_CONV) & tick
                    & (tick_cnt_reg == `APC_CONV_TICKS - 4'h1);
    assign start_conv = (~wr_rise & acq_end)
                      | (wr_rise & (state_reg == APC_ACQ_EXT) & ~byte_reg[`APC_BIT_ACQ]);
    assign pd_byte  = ~byte_reg[`APC_BIT_PD_HI];

    // Bus outputs straight from flip-flops
    assign bus.int_n   = int_n_reg;
    assign bus.dev_d   = dout_reg;
    assign bus.dev_oe  = oe_reg;
    assign power_out   = pwr_reg;
    assign clk_ext_out = clk_ext_reg;
    assign chan_out    = ctrl_reg[2:0];
    assign sgl_out     = ctrl_reg[`APC_BIT_SGL];
    assign hold_out    = hold_reg;

    // Edge history of the bus pins
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_prev_reg   <= 1'b1;
            rd_prev_reg   <= 1'b1;
            cclk_prev_reg <= 1'b0;
        end else begin
            wr_prev_reg   <= bus.wr_n;
            rd_prev_reg   <= bus.rd_n;
            cclk_prev_reg <= bus.conv_clk;
        end
    end

    // Internal conversion clock divider
    always_ff @(posedge clk_in) begin
        if (rst_in || int_tick) begin
            div_cnt_reg <= 8'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
        end
    end

    // Control byte latch while strobe low, applied at its rising edge
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            byte_reg <= 8'h00;
            ctrl_reg <= 8'h00;
        end else begin
            if (~bus.wr_n && ~bus.cs_n) begin
                byte_reg <= bus.data[7:0];
            end
            if (wr_rise) begin
                ctrl_reg <= byte_reg;
            end
        end
    end

    // Clock mode; power-down bytes keep the last one
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            clk_ext_reg <= 1'b1;
        end else if (wr_rise && byte_reg[`APC_BIT_PD_HI]) begin
            clk_ext_reg <= byte_reg[`APC_BIT_PD_LO];
        end
    end

    // Acquisition and conversion sequencer
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg    <= APC_IDLE;
            tick_cnt_reg <= 4'h0;
        end else if (wr_rise) begin
            tick_cnt_reg <= 4'h0;
            if (byte_reg[`APC_BIT_ACQ]) begin
                state_reg <= APC_ACQ_EXT;
            end else if (state_reg == APC_ACQ_EXT) begin
                state_reg <= APC_CONV;
            end else begin
                state_reg <= APC_ACQ_INT;
            end
        end else begin
            unique case (state_reg)
                APC_ACQ_INT: begin
                    if (acq_end) begin
                        state_reg    <= APC_CONV;
                        tick_cnt_reg <= 4'h0;
                    end else if (tick) begin
                        tick_cnt_reg <= tick_cnt_reg + 4'h1;
                    end
                end
                APC_CONV: begin
                    if (conv_end) begin
                        state_reg    <= APC_IDLE;
                        tick_cnt_reg <= 4'h0;
                    end else if (tick) begin
                        tick_cnt_reg <= tick_cnt_reg + 4'h1;
                    end
                end
                APC_IDLE, APC_ACQ_EXT: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // Track/hold and result coding
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sample_reg <= 12'h000;
            result_reg <= 12'h000;
            hold_reg   <= 1'b0;
        end else begin
            if (start_conv) begin
                sample_reg <= analog_in;
            end
            if (conv_end) begin
                result_reg <= code_of(sample_reg, ctrl_reg[`APC_BIT_UNI]);
            end
            hold_reg <= (state_reg == APC_CONV) & ~conv_end & ~wr_rise;
        end
    end

    // Power state: wake on write, sleep after the conversion ends
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pwr_reg     <= APC_ACTIVE;
            pd_pend_reg <= 1'b0;
            pd_stby_reg <= 1'b0;
        end else if (wr_rise) begin
            pwr_reg     <= APC_ACTIVE;
            pd_pend_reg <= pd_byte;
            pd_stby_reg <= byte_reg[`APC_BIT_PD_LO];
        end else if (conv_end && pd_pend_reg) begin
            pwr_reg     <= pd_stby_reg ? APC_STBY : APC_SHUT;
            pd_pend_reg <= 1'b0;
        end
    end

    // Done flag: new byte clears, result sets, read clears
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            int_n_reg <= 1'b1;
        end else if (wr_rise) begin
            int_n_reg <= 1'b1;
        end else if (conv_end) begin
            int_n_reg <= 1'b0;
        end else if (rd_fall) begin
            int_n_reg <= 1'b1;
        end
    end

    // Read port stays live in every power state
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            oe_reg   <= 1'b0;
            dout_reg <= 16'h0000;
        end else begin
            oe_reg   <= ~bus.cs_n & ~bus.rd_n;
            dout_reg <= {4'h0, result_reg};
        end
    end
endmodule

/* hdl/apc_host.sv */
// Host end: drives strobes and conversion clock, keeps waits
`timescale 1ns/100ps
`include "apc_defs.svh"
module apc_host
    import apc_pkg::*;
#(
    parameter int RESET_WAIT = `APC_RESET_CYC,
    parameter int REF_WAIT   = `APC_REF_CYC,
    parameter int WAKE_WAIT  = `APC_WAKE_CYC,
    parameter int CCLK_HALF  = 3,
    parameter int WR_LOW     = 2,
    parameter int RD_LOW     = 4
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    apc_bus_if.host          bus,
    input  wire logic        req_in,
    input  wire logic [7:0]  ctrl_in,
    input  wire logic        pipe_in,
    input  wire logic        flush_in,
    input  wire logic        int_ref_in,
    output logic             ready_out,
    output logic      [11:0] result_out,
    output logic             valid_out
);
    apc_host_t   state_reg;
    logic [15:0] wait_reg;
    logic [3:0]  ph_reg;
    logic [7:0]  cdiv_reg;
    logic        cclk_reg;
    logic        cs_n_reg;
    logic        wr_n_reg;
    logic        rd_n_reg;
    logic        hoe_reg;
    logic [7:0]  hd_reg;
    logic [7:0]  ctrl_reg;
    logic        pipe_reg;
    logic        wake_reg;
    logic        shut_reg;
    logic        pend_reg;
    logic        fly_reg;
    logic        ready_reg;
    logic [11:0] res_reg;
    logic        valid_reg;

    assign bus.cs_n     = cs_n_reg;
    assign bus.wr_n     = wr_n_reg;
    assign bus.rd_n     = rd_n_reg;
    assign bus.conv_clk = cclk_reg;
    assign bus.host_d   = {8'h00, hd_reg};
    assign bus.host_oe  = hoe_reg;
    assign ready_out    = ready_reg;
    assign result_out   = res_reg;
    assign valid_out    = valid_reg;

    // External conversion clock from a divider
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cdiv_reg <= 8'h00;
            cclk_reg <= 1'b0;
        end else if (cdiv_reg == 8'(CCLK_HALF - 1)) begin
            cdiv_reg <= 8'h00;
            cclk_reg <= ~cclk_reg;
        end else begin
            cdiv_reg <= cdiv_reg + 8'h01;
        end
    end

    // Bus sequencer
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= APC_H_RST;
            wait_reg  <= 16'h0000;
            ph_reg    <= 4'h0;
            cs_n_reg  <= 1'b1;
            wr_n_reg  <= 1'b1;
            rd_n_reg  <= 1'b1;
            hoe_reg   <= 1'b0;
            hd_reg    <= 8'h00;
            ctrl_reg  <= 8'h00;
            pipe_reg  <= 1'b0;
            wake_reg  <= 1'b0;
            shut_reg  <= 1'b0;
            pend_reg  <= 1'b0;
            fly_reg   <= 1'b0;
            ready_reg <= 1'b0;
            res_reg   <= 12'h000;
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= 1'b0;
            unique case (state_reg)
                APC_H_RST: begin
                    wait_reg <= wait_reg + 16'h0001;
                    if (wait_reg >= 16'(int_ref_in ? RESET_WAIT + REF_WAIT : RESET_WAIT)) begin
                        state_reg <= APC_H_IDLE;
                        ready_reg <= 1'b1;
                    end
                end
                APC_H_IDLE: begin
                    ph_reg <= 4'h0;
                    if (req_in) begin
                        ready_reg <= 1'b0;
                        ctrl_reg  <= ctrl_in;
                        pipe_reg  <= pipe_in;
                        wake_reg  <= shut_reg;
                        state_reg <= APC_H_WR;
                        // Wake from shutdown through a standby dummy byte
                        hd_reg <= shut_reg ? {`APC_PD_STBY, 6'h00} | (ctrl_in & 8'h1f)
                                           : ctrl_in;
                    end else if (flush_in && pend_reg) begin
                        ready_reg <= 1'b0;
                        state_reg <= APC_H_RD;
                    end
                end
                APC_H_WR: begin
                    ph_reg <= ph_reg + 4'h1;
                    if (ph_reg < 4'(WR_LOW)) begin
                        cs_n_reg <= 1'b0;
                        wr_n_reg <= 1'b0;
                        hoe_reg  <= 1'b1;
                    end else if (ph_reg == 4'(WR_LOW)) begin
                        wr_n_reg <= 1'b1;
                    end else begin
                        cs_n_reg <= 1'b1;
                        hoe_reg  <= 1'b0;
                        ph_reg   <= 4'h0;
                        wait_reg <= 16'h0000;
                        if (wake_reg) begin
                            shut_reg  <= 1'b0;
                            pend_reg  <= 1'b0;
                            state_reg <= APC_H_WAKE;
                        end else begin
                            shut_reg <= (hd_reg[7:6] == `APC_PD_SHUT);
                            if (hd_reg[`APC_BIT_ACQ]) begin
                                state_reg <= APC_H_IDLE;
                                ready_reg <= 1'b1;
                            end else if (pipe_reg && pend_reg) begin
                                fly_reg   <= 1'b1;
                                state_reg <= APC_H_RD;
                            end else begin
                                state_reg <= APC_H_WAIT;
                            end
                        end
                    end
                end
                APC_H_WAKE: begin
                    wait_reg <= wait_reg + 16'h0001;
                    if (wait_reg >= 16'(WAKE_WAIT)) begin
                        wake_reg  <= 1'b0;
                        hd_reg    <= ctrl_reg;
                        state_reg <= APC_H_WR;
                    end
                end
                APC_H_RD: begin
                    ph_reg <= ph_reg + 4'h1;
                    if (ph_reg < 4'(RD_LOW)) begin
                        cs_n_reg <= 1'b0;
                        rd_n_reg <= 1'b0;
                        if (ph_reg == 4'(RD_LOW - 1)) begin
                            res_reg <= bus.data[11:0];
                        end
                    end else begin
                        cs_n_reg  <= 1'b1;
                        rd_n_reg  <= 1'b1;
                        ph_reg    <= 4'h0;
                        valid_reg <= 1'b1;
                        pend_reg  <= 1'b0;
                        fly_reg   <= 1'b0;
                        state_reg <= fly_reg ? APC_H_WAIT : APC_H_IDLE;
                        ready_reg <= ~fly_reg;
                    end
                end
                APC_H_WAIT: begin
                    if (!bus.int_n) begin
                        if (pipe_reg) begin
                            pend_reg  <= 1'b1;
                            state_reg <= APC_H_IDLE;
                            ready_reg <= 1'b1;
                        end else begin
                            state_reg <= APC_H_RD;
                        end
                    end
                end
            endcase
        end
    end
endmodule

/* bench/apc_bus_properties.sv */
// Bus protocol checks between the host and converter ends
`timescale 1ns/100ps
module apc_bus_properties #(
    parameter int RESET_WAIT = 200
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic cs_n,
    input  wire logic wr_n,
    input  wire logic rd_n,
    input  wire logic int_n,
    input  wire logic host_oe,
    input  wire logic dev_oe
);
    logic [15:0] boot_cnt_reg;

    // Cycles since reset release, saturating
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            boot_cnt_reg <= 16'h0000;
        end else if (boot_cnt_reg != 16'hffff) begin
            boot_cnt_reg <= boot_cnt_reg + 16'h0001;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Write strobe released while selected
    sequence write_taken;
        !wr_n ##1 (wr_n && !cs_n);
    endsequence

    // Read strobe held with select for two cycles
    sequence read_held;
        (!cs_n && !rd_n) [*2];
    endsequence

    chk_reset_done_high: assert property ($fell(rst_in) |-> int_n)
        else $error("done flag low after reset");
    chk_host_boot_wait: assert property (boot_cnt_reg < 16'(RESET_WAIT) |-> cs_n)
        else $error("host selected device during reset wait");
    chk_write_bus_driven: assert property (!cs_n && !wr_n |-> host_oe && !dev_oe)
        else $error("control byte not driven by host");
    chk_read_drives_data: assert property (read_held |-> dev_oe)
        else $error("device not driving during read");
    chk_idle_released: assert property (cs_n [*2] |-> !dev_oe)
        else $error("device drives bus while not selected");
    chk_frame_min_len: assert property (write_taken |=> int_n [*8])
        else $error("done flag not high after control write");
    chk_read_clears_done: assert property ($fell(rd_n) && !cs_n && !int_n |=> int_n)
        else $error("done flag not cleared by read");
    chk_done_holds_low: assert property (!int_n && cs_n && $past(cs_n) |=> !int_n)
        else $error("done flag dropped without bus access");
endmodule

/* bench/adc_power_and_sequencing_control_tb.sv */
// Self-checking bench joining host and converter ends
`timescale 1ns/100ps
`include "apc_defs.svh"
module adc_power_and_sequencing_control_tb
    import apc_pkg::*;
;
    localparam int BOOT  = `APC_RESET_CYC;
    localparam int REFW  = 20;
    localparam int WAKEW = 200;
    logic        clk_in     = 1'b0;
    logic        rst_in     = 1'b1;
    logic        req_in     = 1'b0;
    logic [7:0]  ctrl_in    = 8'h00;
    logic        pipe_in    = 1'b0;
    logic        flush_in   = 1'b0;
    logic        int_ref_in = 1'b1;
    logic [11:0] analog_in  = 12'h000;
    logic        ready_out, sgl_out, hold_out, valid_out, clk_ext_out;
    logic [2:0]  power_out, chan_out;
    logic [11:0] result_out;
    logic [11:0] exp_q [$];
    int          errors       = 0;
    int          total_checks = 0;
    int          cycles       = 0;

    apc_bus_if i_apc_bus_if ();

    apc_dev i_apc_dev (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .bus         (i_apc_bus_if),
        .analog_in   (analog_in),
        .power_out   (power_out),
        .clk_ext_out (clk_ext_out),
        .chan_out    (chan_out),
        .sgl_out     (sgl_out),
        .hold_out    (hold_out)
    );

    apc_host #(.REF_WAIT(REFW), .WAKE_WAIT(WAKEW)) i_apc_host (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .bus        (i_apc_bus_if),
        .req_in     (req_in),
        .ctrl_in    (ctrl_in),
        .pipe_in    (pipe_in),
        .flush_in   (flush_in),
        .int_ref_in (int_ref_in),
        .ready_out  (ready_out),
        .result_out (result_out),
        .valid_out  (valid_out)
    );

    apc_bus_properties #(.RESET_WAIT(BOOT)) i_apc_bus_properties (
        .clk_in  (clk_in),
        .rst_in  (rst_in),
        .cs_n    (i_apc_bus_if.cs_n),
        .wr_n    (i_apc_bus_if.wr_n),
        .rd_n    (i_apc_bus_if.rd_n),
        .int_n   (i_apc_bus_if.int_n),
        .host_oe (i_apc_bus_if.host_oe),
        .dev_oe  (i_apc_bus_if.dev_oe)
    );

    // Clock source
    always #25 clk_in = ~clk_in;

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Code expected from the control byte and the input level
    function automatic logic [11:0] exp_code(input logic [7:0] c, input logic [11:0] a);
        return c[`APC_BIT_UNI] ? a : a ^ `APC_BIP_FLIP;
    endfunction

    // Hang guard
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    // Results compared in request order
    always @(posedge clk_in) begin
        if (!rst_in && valid_out === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("extra_result", 12'h001, 12'h000);
            end else begin
                check("result", result_out, exp_q.pop_front());
            end
        end
    end

    // Wait for host idle; power must stay up while converting
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready_out !== 1'b1 && n < 4000) begin
            if (hold_out === 1'b1) check("pwr_conv", 12'(power_out), 12'(APC_ACTIVE));
            @(posedge clk_in);
            n++;
        end
        if (n >= 4000) check("ready_to", 12'h000, 12'h001);
    endtask

    task automatic do_req(input logic [7:0] c, input logic p, input logic r, input logic [11:0] a);
        wait_ready();
        analog_in <= a;
        req_in    <= 1'b1;
        ctrl_in   <= c;
        pipe_in   <= p;
        if (r) exp_q.push_back(exp_code(c, a));
        @(posedge clk_in);
        req_in <= 1'b0;
        @(posedge clk_in);
        wait_ready();
    endtask

    // Reset for five cycles, then time the host's start-up wait
    task automatic boot(input logic r);
        int n;
        n = 0;
        int_ref_in <= r;
        rst_in     <= 1'b1;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        #1;
        check("int_n_rst", 12'(i_apc_bus_if.int_n), 12'h001);
        check("clk_ext_rst", 12'(clk_ext_out), 12'h001);
        check("power_rst", 12'(power_out), 12'(APC_ACTIVE));
        while (ready_out !== 1'b1 && n < 2000) begin
            @(posedge clk_in);
            n++;
        end
        check("boot_wait", 12'(n), 12'(BOOT + (r ? REFW : 0) + 1));
    endtask

    initial begin
        logic [7:0]  c;
        logic [11:0] a;
        logic        e;
        int          n;
        a = 12'($urandom(33));
        boot(1'b1);
        // Random frames in both clock modes, with code extremes first
        for (int i = 0; i < 12; i++) begin
            c = {1'b1, 1'($urandom()), 1'b0, 5'($urandom())};
            a = i == 0 ? 12'h000 : i == 1 ? 12'hfff : i == 2 ? 12'h800 : 12'($urandom());
            do_req(c, 1'b0, 1'b1, a);
            check("clk_mode", 12'(clk_ext_out), 12'(c[`APC_BIT_PD_LO]));
            check("chan", 12'(chan_out), 12'(c[2:0]));
            check("sgl", 12'(sgl_out), 12'(c[`APC_BIT_SGL]));
        end
        // Shutdown then standby, each followed by a wake frame
        for (int m = 0; m < 2; m++) begin
            e = clk_ext_out;
            c = {1'b0, 1'(m), 6'h08};
            do_req(c, 1'b0, 1'b1, 12'($urandom()));
            check("pd_mode", 12'(power_out), 12'(m ? APC_STBY : APC_SHUT));
            check("pd_clk", 12'(clk_ext_out), 12'(e));
            n = cycles;
            do_req(8'hc8, 1'b0, 1'b1, 12'($urandom()));
            check("wake", 12'(power_out), 12'(APC_ACTIVE));
            check("wake_wait", 12'((cycles - n) > WAKEW), 12'(m == 0));
        end
        // Open acquisition, then the converting byte
        a = 12'($urandom());
        do_req(8'he8, 1'b0, 1'b0, a);
        repeat (150) @(posedge clk_in);
        check("acq_open", 12'(i_apc_bus_if.int_n), 12'h001);
        check("hold_acq", 12'(hold_out), 12'h000);
        do_req(8'hc8, 1'b0, 1'b1, a);
        // Pipelined frames in both clock modes, then flush the last result
        for (int i = 0; i < 4; i++) begin
            do_req({1'b1, ~i[1], 2'b00, i[0], 3'(i)}, 1'b1, 1'b1, 12'($urandom()));
        end
        flush_in <= 1'b1;
        @(posedge clk_in);
        flush_in <= 1'b0;
        @(posedge clk_in);
        wait_ready();
        // Park in shutdown, internal clock, done flag low; reset without reference wait
        do_req(8'h00, 1'b1, 1'b0, 12'($urandom()));
        check("park_pd", 12'(power_out), 12'(APC_SHUT));
        boot(1'b0);
        do_req(8'hc8, 1'b0, 1'b1, 12'($urandom()));
        repeat (20) @(posedge clk_in);
        check("pending", 12'(exp_q.size()), 12'h000);
        final_report();
    end
endmodule
